// file: rtl/birq_top.v
// Board interrupt gathering and NMI gating, APB register slave.
// Assumes all interrupt, NMI, switch and chip-select pins are asynchronous
// and active low; one clock pclk, asynchronous active-low reset presetn.
//
// What this block does
// [RULE_01] PCI status bits 11..8 show live INTD..INTA levels, low means requesting.
// [RULE_02] Reading PCI status clears nothing; the remote board releases its line.
// [RULE_03] PCI enable bits 11..8 writable, 1 accepts, 0 masks, reset 0.
// [RULE_04] Level interrupt asserts while a PCI status bit is 0 and enabled.
// [RULE_05] External status bits 12 and 11 show live board line levels.
// [RULE_06] External status bit 8 shows the serial carrier-detect level.
// [RULE_07] External status bits 10 and 9 always read 1.
// [RULE_08] External enable bits 12, 11, 8 gate their sources; software writes 0 to 10, 9.
// [RULE_09] Control bit 10 routes chip-select areas five and six to expansion bus.
// [RULE_10] Control bit 9 passes abort-switch presses to the NMI output.
// [RULE_11] Control bit 8 passes bus and emulator NMI requests to the NMI output.
// [RULE_12] Status registers are read-only; writes change nothing.
// [RULE_13] Level interrupt is the OR of all enabled PCI and external terms.
// [RULE_14] Unused bits ignore writes and read as a stable value.
`timescale 1ns/1ns
`include "birq_defines.vh"
module birq_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire [31:0] prdata,
   output wire        pslverr,
   input  wire [3:0]  pci_irq_n,
   input  wire        board_irq_line_a_n,
   input  wire        board_irq_line_b_n,
   input  wire        serial_carrier_irq_n,
   input  wire        bus_nmi_input_n,
   input  wire        emulator_nmi_pin_n,
   input  wire        abort_switch_n,
   input  wire        chip_select_area_five_n,
   input  wire        chip_select_area_six_n,
   output wire        cpu_irq_level_line_n,
   output wire        cpu_nmi_req_n,
   output wire        exp_area_five_n,
   output wire        exp_area_six_n,
   output wire        cs_area_route_en,
   output wire        evt_irq
);
   // One synchroniser bit per input pin, chip selects included
   localparam NPIN = 12;

   // Synchronised pins
   wire [NPIN-1:0] pin_raw;
   wire [NPIN-1:0] pin_lvl;
   wire [3:0]      pci_lvl;
   wire            brd_a_lvl;
   wire            brd_b_lvl;
   wire            carrier_lvl;
   wire            bus_nmi_lvl;
   wire            emu_nmi_lvl;
   wire            abort_lvl;
   wire            cs5_lvl;
   wire            cs6_lvl;

   // Control registers
   reg  [3:0]  pci_irq_gate_ff;
   reg  [4:0]  ext_irq_gate_ff;
   reg  [2:0]  nmi_gate_ff;

   // Pin outputs
   reg         cpu_irq_level_line_n_ff;
   reg         cpu_nmi_req_n_ff;
   reg         exp_area_five_n_ff;
   reg         exp_area_six_n_ff;
   reg         cs_area_route_en_ff;

   // Edge history for event capture
   reg  [7:0]  evt_lvl_ff;

   // APB slave state
   reg         pready_ff;
   reg  [31:0] prdata_ff;
   reg         pslverr_ff;

   // Combinational terms
   wire        cs_area_route_en_w;
   wire        abort_nmi_enable;
   wire        bus_nmi_enable;
   wire [2:0]  ext_lvl;
   wire [2:0]  ext_gate_used;
   wire        nxt_irq;
   wire        nxt_nmi;
   wire [7:0]  evt_now;
   wire [7:0]  evt_pulse;
   wire [7:0]  evt_status;
   wire [7:0]  evt_mask;
   wire        access;
   wire        commit;
   wire        wr_commit;
   wire        mask_wr;
   wire [7:0]  evt_rd_clr;
   reg  [31:0] rd_word;
   reg         rd_hit;
   reg         sel_pci_enable;
   reg         sel_ext_enable;
   reg         sel_nmi_ctrl;
   reg         sel_evt_status;
   reg         sel_evt_mask;
   reg  [15:0] pci_word;
   reg  [15:0] ext_word;
   reg  [15:0] pci_en_word;
   reg  [15:0] ext_en_word;
   reg  [15:0] nmi_word;

   // Bit order here fixes the pin_lvl slices below
   assign pin_raw = {chip_select_area_six_n, chip_select_area_five_n,
                     abort_switch_n, emulator_nmi_pin_n, bus_nmi_input_n,
                     serial_carrier_irq_n, board_irq_line_b_n,
                     board_irq_line_a_n, pci_irq_n};

   birq_sync #(
      .W       (NPIN),
      .RST_VAL (`BIRQ_PIN_IDLE_RST)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (pin_raw),
      .q       (pin_lvl)
   );

   assign pci_lvl     = pin_lvl[3:0];
   assign brd_a_lvl   = pin_lvl[4];
   assign brd_b_lvl   = pin_lvl[5];
   assign carrier_lvl = pin_lvl[6];
   assign bus_nmi_lvl = pin_lvl[7];
   assign emu_nmi_lvl = pin_lvl[8];
   assign abort_lvl   = pin_lvl[9];
   assign cs5_lvl     = pin_lvl[10];
   assign cs6_lvl     = pin_lvl[11];

   assign cs_area_route_en_w = nmi_gate_ff[`BIRQ_NMI_ROUTE - `BIRQ_NMI_LSB];
   assign abort_nmi_enable   = nmi_gate_ff[`BIRQ_NMI_ABORT - `BIRQ_NMI_LSB];
   assign bus_nmi_enable     = nmi_gate_ff[`BIRQ_NMI_BUS - `BIRQ_NMI_LSB];

   // Reserved enable bits 10 and 9 are stored but gate nothing
   assign ext_lvl       = {brd_b_lvl, brd_a_lvl, carrier_lvl};
   assign ext_gate_used = {ext_irq_gate_ff[`BIRQ_EXT_BOARD_B - `BIRQ_EXT_LSB],
                           ext_irq_gate_ff[`BIRQ_EXT_BOARD_A - `BIRQ_EXT_LSB],
                           ext_irq_gate_ff[`BIRQ_EXT_CARRIER - `BIRQ_EXT_LSB]};

   assign nxt_irq = (|(~pci_lvl & pci_irq_gate_ff)) |  // RULE_04
                    (|(~ext_lvl & ext_gate_used));       // RULE_13

   // NMI leaves as a level; the host takes its falling edge,
   // so a request held low gives one NMI only
   assign nxt_nmi = (abort_nmi_enable & ~abort_lvl) |                    // RULE_10
                    (bus_nmi_enable & (~bus_nmi_lvl | ~emu_nmi_lvl));    // RULE_11

   // Events are falling edges of the request lines and abort presses
   assign evt_now   = {abort_lvl, brd_b_lvl, brd_a_lvl, carrier_lvl, pci_lvl};
   assign evt_pulse = evt_lvl_ff & ~evt_now;

   // APB: one wait state, data and ready both from flops
   assign access    = psel & penable;
   assign commit    = access & pready_ff;
   assign wr_commit = commit & pwrite & ~pslverr_ff;
   assign mask_wr   = wr_commit & sel_evt_mask;
   assign evt_rd_clr = (commit & ~pwrite & sel_evt_status) ? prdata_ff[7:0] : 8'h00;

   always @* begin
      pci_word    = 16'h0000;
      pci_word[`BIRQ_PCI_MSB:`BIRQ_PCI_LSB] = pci_lvl;  // RULE_01
      ext_word    = 16'h0000;
      ext_word[`BIRQ_EXT_BOARD_B] = brd_b_lvl;          // RULE_05
      ext_word[`BIRQ_EXT_BOARD_A] = brd_a_lvl;          // RULE_05
      ext_word[`BIRQ_EXT_CARRIER] = carrier_lvl;        // RULE_06
      ext_word[`BIRQ_EXT_RSVD_HI] = 1'b1;               // RULE_07
      ext_word[`BIRQ_EXT_RSVD_LO] = 1'b1;               // RULE_07
      pci_en_word = 16'h0000;
      pci_en_word[`BIRQ_PCI_MSB:`BIRQ_PCI_LSB] = pci_irq_gate_ff;
      ext_en_word = 16'h0000;
      ext_en_word[`BIRQ_EXT_MSB:`BIRQ_EXT_LSB] = ext_irq_gate_ff;
      nmi_word    = 16'h0000;
      nmi_word[`BIRQ_NMI_MSB:`BIRQ_NMI_LSB] = nmi_gate_ff;
   end

   // Address decode; unused bits read as zero
   always @* begin
      rd_word        = 32'h0000_0000;
      rd_hit         = 1'b1;
      sel_pci_enable = 1'b0;
      sel_ext_enable = 1'b0;
      sel_nmi_ctrl   = 1'b0;
      sel_evt_status = 1'b0;
      sel_evt_mask   = 1'b0;
      if (paddr == (`BIRQ_IDX_PCI_STATUS << `BIRQ_IDX_SHIFT)) begin
         rd_word = {16'h0000, pci_word};  // RULE_14
      end else if (paddr == (`BIRQ_IDX_PCI_ENABLE << `BIRQ_IDX_SHIFT)) begin
         rd_word        = {16'h0000, pci_en_word};
         sel_pci_enable = 1'b1;
      end else if (paddr == (`BIRQ_IDX_EXT_STATUS << `BIRQ_IDX_SHIFT)) begin
         rd_word = {16'h0000, ext_word};
      end else if (paddr == (`BIRQ_IDX_EXT_ENABLE << `BIRQ_IDX_SHIFT)) begin
         rd_word        = {16'h0000, ext_en_word};
         sel_ext_enable = 1'b1;
      end else if (paddr == (`BIRQ_IDX_NMI_CTRL << `BIRQ_IDX_SHIFT)) begin
         rd_word      = {16'h0000, nmi_word};
         sel_nmi_ctrl = 1'b1;
      end else if (paddr == (`BIRQ_IDX_EVT_STATUS << `BIRQ_IDX_SHIFT)) begin
         rd_word        = {24'h00_0000, evt_status};
         sel_evt_status = 1'b1;
      end else if (paddr == (`BIRQ_IDX_EVT_MASK << `BIRQ_IDX_SHIFT)) begin
         rd_word      = {24'h00_0000, evt_mask};
         sel_evt_mask = 1'b1;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         // Ready lasts one cycle; an access held past it is taken again two cycles later
         pready_ff  <= access & ~pready_ff;
         pslverr_ff <= access & ~pready_ff & ~rd_hit;
         if (access & ~pready_ff) begin
            // Snapshot is also the clear vector for the sticky events
            prdata_ff <= rd_word;  // RULE_02
         end else begin
            prdata_ff <= 32'h0000_0000;
         end
      end
   end

   // Status addresses have no write path
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pci_irq_gate_ff <= `BIRQ_PCI_ENABLE_RST;  // RULE_03
         ext_irq_gate_ff <= `BIRQ_EXT_ENABLE_RST;  // RULE_08
         nmi_gate_ff     <= `BIRQ_NMI_CTRL_RST;    // RULE_09
      end else if (wr_commit) begin              // RULE_12
         if (sel_pci_enable) begin
            pci_irq_gate_ff <= pwdata[`BIRQ_PCI_MSB:`BIRQ_PCI_LSB];  // RULE_03
         end
         // Reserved enable bits 10 and 9 are kept as written
         if (sel_ext_enable) begin
            ext_irq_gate_ff <= pwdata[`BIRQ_EXT_MSB:`BIRQ_EXT_LSB];  // RULE_08
         end
         if (sel_nmi_ctrl) begin
            nmi_gate_ff <= pwdata[`BIRQ_NMI_MSB:`BIRQ_NMI_LSB];
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_irq_level_line_n_ff <= 1'b1;
         cpu_nmi_req_n_ff        <= 1'b1;
         exp_area_five_n_ff      <= 1'b1;
         exp_area_six_n_ff       <= 1'b1;
         cs_area_route_en_ff     <= 1'b0;
         evt_lvl_ff              <= 8'hff;
      end else begin
         cpu_irq_level_line_n_ff <= ~nxt_irq;  // RULE_13
         cpu_nmi_req_n_ff        <= ~nxt_nmi;
         // Blocked selects stay idle high on the expansion bus
         exp_area_five_n_ff      <= cs5_lvl | ~cs_area_route_en_w;  // RULE_09
         exp_area_six_n_ff       <= cs6_lvl | ~cs_area_route_en_w;  // RULE_09
         cs_area_route_en_ff     <= cs_area_route_en_w;
         evt_lvl_ff              <= evt_now;
      end
   end

   // Event capture is extra to the level path and never feeds it
   birq_evt #(
      .W        (8),
      .MASK_RST (`BIRQ_EVT_MASK_RST)
   ) u_evt (
      .pclk       (pclk),
      .presetn    (presetn),
      .evt        (evt_pulse),
      .rd_clr     (evt_rd_clr),
      .mask_wr    (mask_wr),
      .mask_wdata (pwdata[7:0]),
      .status     (evt_status),
      .mask       (evt_mask),
      .irq        (evt_irq)
   );

   assign pready               = pready_ff;
   assign prdata               = prdata_ff;
   assign pslverr              = pslverr_ff;
   assign cpu_irq_level_line_n = cpu_irq_level_line_n_ff;
   assign cpu_nmi_req_n        = cpu_nmi_req_n_ff;
   assign exp_area_five_n      = exp_area_five_n_ff;
   assign exp_area_six_n       = exp_area_six_n_ff;
   assign cs_area_route_en     = cs_area_route_en_ff;
endmodule

// file: rtl/birq_defines.vh
// Constants of the board interrupt and NMI gating block.
// Included by bare name; definitions only.
`ifndef BIRQ_DEFINES_VH
`define BIRQ_DEFINES_VH

// Register indices; byte address is four times the index
`define BIRQ_IDX_PCI_STATUS 32'h0040_0000
`define BIRQ_IDX_PCI_ENABLE 32'h0040_0002
`define BIRQ_IDX_EXT_STATUS 32'h0400_0004
`define BIRQ_IDX_EXT_ENABLE 32'h0040_0006
`define BIRQ_IDX_NMI_CTRL   32'h0400_0008
`define BIRQ_IDX_EVT_STATUS 32'h0400_0010
`define BIRQ_IDX_EVT_MASK   32'h0400_0012
`define BIRQ_IDX_SHIFT      2

// Field positions
`define BIRQ_PCI_LSB        8
`define BIRQ_PCI_MSB        11
`define BIRQ_EXT_LSB        8
`define BIRQ_EXT_MSB        12
`define BIRQ_EXT_CARRIER    8
`define BIRQ_EXT_RSVD_LO    9
`define BIRQ_EXT_RSVD_HI    10
`define BIRQ_EXT_BOARD_A    11
`define BIRQ_EXT_BOARD_B    12
`define BIRQ_NMI_LSB        8
`define BIRQ_NMI_MSB        10
`define BIRQ_NMI_BUS        8
`define BIRQ_NMI_ABORT      9
`define BIRQ_NMI_ROUTE      10
`define BIRQ_EVT_MSB        7

// Reset values
`define BIRQ_PCI_ENABLE_RST 4'h0
`define BIRQ_EXT_ENABLE_RST 5'h00
`define BIRQ_NMI_CTRL_RST   3'h0
`define BIRQ_EVT_MASK_RST   8'h00
`define BIRQ_PIN_IDLE_RST   12'hfff

`endif

// file: rtl/birq_sync.v
// Two-stage synchroniser for a bundle of pin levels.
// Assumes the pins are asynchronous to pclk; stage one is read only by stage two.
`timescale 1ns/1ns
module birq_sync #(
   parameter          W       = 1,
   parameter [W-1:0]  RST_VAL = {W{1'b1}}
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule

// file: rtl/birq_evt.v
// Sticky event status with a mask and one level interrupt.
// Assumes one-cycle event pulses and a read-clear vector from the bus slave.
`timescale 1ns/1ns
module birq_evt #(
   parameter          W       = 8,
   parameter [W-1:0]  MASK_RST = {W{1'b0}}
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire [W-1:0] evt,
   input  wire [W-1:0] rd_clr,
   input  wire         mask_wr,
   input  wire [W-1:0] mask_wdata,
   output wire [W-1:0] status,
   output wire [W-1:0] mask,
   output wire         irq
);
   reg [W-1:0] status_ff;
   reg [W-1:0] mask_ff;
   reg         irq_ff;
   wire [W-1:0] nxt_status;

   // Set beats clear so an event landing on the read is kept
   assign nxt_status = (status_ff & ~rd_clr) | evt;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_ff <= {W{1'b0}};
         mask_ff   <= MASK_RST;
         irq_ff    <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         if (mask_wr) begin
            mask_ff <= mask_wdata;
         end
         irq_ff <= |(nxt_status & (mask_wr ? mask_wdata : mask_ff));
      end
   end

   assign status = status_ff;
   assign mask   = mask_ff;
   assign irq    = irq_ff;
endmodule

// file: tb/birq_monitor.sv
// Checker for birq_top: APB answer timing, register readback, level outputs.
// Assumes it is bound to birq_top and sees its ports only.
`timescale 1ns/1ns
`include "birq_defines.vh"
module birq_monitor (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire [31:0] prdata,
   input wire        pslverr,
   input wire [3:0]  pci_irq_n,
   input wire        board_irq_line_a_n,
   input wire        board_irq_line_b_n,
   input wire        serial_carrier_irq_n,
   input wire        bus_nmi_input_n,
   input wire        emulator_nmi_pin_n,
   input wire        abort_switch_n,
   input wire        cpu_irq_level_line_n,
   input wire        cpu_nmi_req_n,
   input wire        cs_area_route_en
);
   localparam [31:0] A_PE = `BIRQ_IDX_PCI_ENABLE << `BIRQ_IDX_SHIFT,
                     A_ES = `BIRQ_IDX_EXT_STATUS << `BIRQ_IDX_SHIFT,
                     A_EE = `BIRQ_IDX_EXT_ENABLE << `BIRQ_IDX_SHIFT,
                     A_NC = `BIRQ_IDX_NMI_CTRL << `BIRQ_IDX_SHIFT;
   wire [9:0] pin = {abort_switch_n, emulator_nmi_pin_n, bus_nmi_input_n,
                     serial_carrier_irq_n, board_irq_line_b_n, board_irq_line_a_n, pci_irq_n};
   wire       wr  = psel && penable && pready && pwrite;
   wire       rd  = psel && penable && pready && !pwrite && !pslverr;
   reg  [9:0] s1_ff, s2_ff;
   reg  [3:0] pe_ff;
   reg  [4:0] ee_ff;
   reg  [2:0] nc_ff;
   reg        irq_ff, nmi_ff;
   // Same two sync flops plus output flop as the block, so levels match exactly
   wire nxt_irq = ~(|(~s2_ff[3:0] & pe_ff) | (~s2_ff[4] & ee_ff[3])
                    | (~s2_ff[5] & ee_ff[4]) | (~s2_ff[6] & ee_ff[0]));
   wire nxt_nmi = ~((nc_ff[1] & ~s2_ff[9]) | (nc_ff[0] & ~(s2_ff[7] & s2_ff[8])));
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff  <= 10'h3ff;
         s2_ff  <= 10'h3ff;
         pe_ff  <= 4'h0;
         ee_ff  <= 5'h00;
         nc_ff  <= 3'h0;
         irq_ff <= 1'b1;
         nmi_ff <= 1'b1;
      end else begin
         s1_ff  <= pin;
         s2_ff  <= s1_ff;
         irq_ff <= nxt_irq;
         nmi_ff <= nxt_nmi;
         if (wr && paddr == A_PE)
            pe_ff <= pwdata[11:8];
         if (wr && paddr == A_EE)
            ee_ff <= pwdata[12:8];
         if (wr && paddr == A_NC)
            nc_ff <= pwdata[10:8];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   a_one_wait: assert property ($rose(penable) && psel |-> s_wait ##1 s_answer)
      else $error("answer not after one wait state");
   a_idle_rdata: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data not zero outside answer");
   a_irq_level: assert property (
      cpu_irq_level_line_n == irq_ff) else $error("level interrupt wrong");
   a_nmi_gating: assert property (
      cpu_nmi_req_n == nmi_ff) else $error("nmi output wrong");
   a_route_copy: assert property (
      wr && paddr == A_NC |-> ##2 cs_area_route_en == nc_ff[2]) else $error("route flag wrong");
   a_rsvd_ones: assert property (
      rd && paddr == A_ES |-> prdata[10:9] == 2'b11) else $error("reserved bits not 1");
   a_pci_gate_read: assert property (
      rd && paddr == A_PE |-> prdata == {20'h0_0000, pe_ff, 8'h00}) else $error("pci gate read");
   a_ext_gate_read: assert property (
      rd && paddr == A_EE |-> prdata == {19'h0_0000, ee_ff, 8'h00}) else $error("ext gate read");
endmodule
bind birq_top birq_monitor u_mon (.*);

// file: tb/birq_cpu_model.sv
// Host processor model on the level interrupt and NMI outputs.
// Assumes active-low levels; the NMI input is edge sensitive.
`timescale 1ns/1ns
module birq_cpu_model (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       irq_n,
   input  wire       nmi_n,
   output reg  [7:0] nmi_cnt,
   output reg        irq_taken
);
   reg nmi_ff;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_ff    <= 1'b1;
         nmi_cnt   <= 8'h00;
         irq_taken <= 1'b0;
      end else begin
         nmi_ff <= nmi_n;
         // Only a fresh fall counts, as on a real NMI pin
         if (nmi_ff && !nmi_n)
            nmi_cnt <= nmi_cnt + 8'h01;
         if (!irq_n)
            irq_taken <= 1'b1;
      end
   end
endmodule

// file: tb/tb_birq_top.sv
// Testbench for birq_top: registers over APB, pin levels, interrupt and NMI gating.
// Assumes a 100 ns clock; checker bound separately; host model on the outputs.
`timescale 1ns/1ns
`include "birq_defines.vh"
module tb_birq_top;
   localparam [31:0] A_PS = `BIRQ_IDX_PCI_STATUS << `BIRQ_IDX_SHIFT,
                     A_PE = `BIRQ_IDX_PCI_ENABLE << `BIRQ_IDX_SHIFT,
                     A_ES = `BIRQ_IDX_EXT_STATUS << `BIRQ_IDX_SHIFT,
                     A_EE = `BIRQ_IDX_EXT_ENABLE << `BIRQ_IDX_SHIFT,
                     A_NC = `BIRQ_IDX_NMI_CTRL << `BIRQ_IDX_SHIFT,
                     A_VS = `BIRQ_IDX_EVT_STATUS << `BIRQ_IDX_SHIFT,
                     A_VM = `BIRQ_IDX_EVT_MASK << `BIRQ_IDX_SHIFT;
   reg         pclk, presetn, psel, penable, pwrite, er;
   reg  [31:0] paddr, pwdata, rd;
   reg  [11:0] pn;
   wire        pready, pslverr, irq_n, nmi_n, a5_n, a6_n, route, evt_irq, irq_taken;
   wire [31:0] prdata;
   wire [7:0]  nmi_cnt;
   integer     n_mismatch, total_checks, i;
   birq_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .pci_irq_n(pn[3:0]), .board_irq_line_a_n(pn[4]),
      .board_irq_line_b_n(pn[5]), .serial_carrier_irq_n(pn[6]), .bus_nmi_input_n(pn[7]),
      .emulator_nmi_pin_n(pn[8]), .abort_switch_n(pn[9]), .chip_select_area_five_n(pn[10]),
      .chip_select_area_six_n(pn[11]), .cpu_irq_level_line_n(irq_n), .cpu_nmi_req_n(nmi_n),
      .exp_area_five_n(a5_n), .exp_area_six_n(a6_n), .cs_area_route_en(route),
      .evt_irq(evt_irq));
   birq_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .irq_n(irq_n), .nmi_n(nmi_n),
      .nmi_cnt(nmi_cnt), .irq_taken(irq_taken));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task chk(input [31:0] g, input [31:0] e);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task apb(input w, input [31:0] a, input [31:0] d);
      integer k;
      begin
         @(posedge pclk);
         psel   <= 1'b1;
         pwrite <= w;
         paddr  <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         k = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k = k + 1;
         end
         chk(k < 20, 1'b1);
         rd = prdata;
         er = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wr(input [31:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input [31:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0000_0000);
         chk(rd, e);
      end
   endtask
   // Four settled cycles cover the two sync flops and the output flop
   task pin(input integer n, input v);
      begin
         @(posedge pclk);
         pn[n] <= v;
         repeat (4) @(negedge pclk);
      end
   endtask
   task w2;
      repeat (2) @(negedge pclk);
   endtask
   task t_reset;
      begin
         @(negedge pclk);
         chk({irq_n, nmi_n, a5_n, a6_n, route, evt_irq}, 6'h3c);
         chk({pready, pslverr}, 2'b00);
         chk(prdata, 32'h0000_0000);
         rdc(A_PE, 32'h0000_0000);
         rdc(A_EE, 32'h0000_0000);
         rdc(A_NC, 32'h0000_0000);
         rdc(A_PS, 32'h0000_0F00);
         rdc(A_ES, 32'h0000_1F00);
      end
   endtask
   task t_pci;
      reg [31:0] e;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            e = 32'h0000_0F00 ^ (32'h0000_0100 << i);
            pin(i, 1'b0);
            rdc(A_PS, e);
            rdc(A_PS, e);
            chk(irq_n, 1'b1);
            wr(A_PS, 32'h0000_0000);
            rdc(A_PS, e);
            wr(A_PE, 32'h0000_0100 << i);
            w2;
            chk(irq_n, 1'b0);
            wr(A_PE, e);
            w2;
            chk(irq_n, 1'b1);
            pin(i, 1'b1);
            wr(A_PE, 32'h0000_0000);
         end
      end
   endtask
   task t_ext;
      integer j, p, b;
      begin
         for (j = 0; j < 3; j = j + 1) begin
            p = (j == 0) ? 6 : j + 3;
            b = (j == 0) ? 8 : j + 10;
            pin(p, 1'b0);
            rdc(A_ES, 32'h0000_1F00 ^ (32'h0000_0001 << b));
            chk(irq_n, 1'b1);
            wr(A_EE, 32'h0000_0001 << b);
            w2;
            chk(irq_n, 1'b0);
            wr(A_EE, 32'h0000_0000);
            w2;
            chk(irq_n, 1'b1);
            pin(p, 1'b1);
         end
      end
   endtask
   task t_nmi;
      begin
         pin(9, 1'b0);
         chk(nmi_n, 1'b1);
         wr(A_NC, 32'h0000_0200);
         w2;
         chk(nmi_n, 1'b0);
         pin(9, 1'b1);
         wr(A_NC, 32'h0000_0100);
         for (i = 7; i < 9; i = i + 1) begin
            pin(i, 1'b0);
            chk(nmi_n, 1'b0);
            pin(i, 1'b1);
         end
         wr(A_NC, 32'h0000_0000);
         pin(7, 1'b0);
         chk(nmi_n, 1'b1);
         pin(7, 1'b1);
         chk(nmi_cnt, 8'h03);
      end
   endtask
   task t_route;
      begin
         pin(10, 1'b0);
         chk(a5_n, 1'b1);
         wr(A_NC, 32'h0000_0400);
         w2;
         chk({route, a5_n}, 2'b10);
         pin(10, 1'b1);
         pin(11, 1'b0);
         chk(a6_n, 1'b0);
         wr(A_NC, 32'h0000_0000);
         w2;
         chk(a6_n, 1'b1);
         pin(11, 1'b1);
      end
   endtask
   task t_misc;
      begin
         apb(1'b0, 32'h0000_0004, 32'h0000_0000);
         chk(er, 1'b1);
         chk(rd, 32'h0000_0000);
         wr(A_ES, 32'h0000_0000);
         rdc(A_ES, 32'h0000_1F00);
         wr(A_PE, 32'hFFFF_FFFF);
         rdc(A_PE, 32'h0000_0F00);
         wr(A_PE, 32'h0000_0000);
         apb(1'b0, A_VS, 32'h0000_0000);
         pin(0, 1'b0);
         pin(0, 1'b1);
         wr(A_VM, 32'h0000_0001);
         w2;
         chk(evt_irq, 1'b1);
         wr(A_VM, 32'h0000_0000);
         w2;
         chk(evt_irq, 1'b0);
         wr(A_VM, 32'h0000_0001);
         rdc(A_VS, 32'h0000_0001);
         w2;
         chk(evt_irq, 1'b0);
         rdc(A_VS, 32'h0000_0000);
         chk(irq_taken, 1'b1);
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_mismatch);
         if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      #1_000_000;
      n_mismatch = n_mismatch + 1;
      end_of_test;
   end
   initial begin
      n_mismatch = 0;
      total_checks = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata} = 68'h0;
      pn = 12'hfff;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_pci;
      t_ext;
      t_nmi;
      t_route;
      t_misc;
      end_of_test;
   end
endmodule
